// ===== include/defect_mon_defs.svh
// Constants for the T1 receive defect monitor: register map, field layout,
// reset values and persistence counts.
// Assumes a 125 MHz ref_clk; the per-bit and framing-bit strobes come from the framer.
`ifndef DEFECT_MON_DEFS_SVH
`define DEFECT_MON_DEFS_SVH

// ****************************************************************
// Register map (word index on the 4-bit register port)
// ****************************************************************
`define REG_ALARM_STATUS      4'h0
`define REG_ALARM_MASK        4'h1
`define REG_FRAME_THRESHOLD   4'h2

// ****************************************************************
// Status register layout
// ****************************************************************
`define ST_FRAME_LOSS_LIVE    7
`define ST_ALARM_IND_LIVE     6
`define ST_REMOTE_ALARM_LIVE  5
`define ST_SIGNAL_LOSS_LIVE   4
`define ST_FRAME_LOSS_CHG     2
`define ST_ALARM_IND_CHG      1
`define ST_REMOTE_ALARM_CHG   0

// ****************************************************************
// Reset values
// ****************************************************************
`define MASK_RST              3'h0
`define TOLERANCE_RST         4'h2
`define WINDOW_RST            4'h4

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_PS         8000
`define MS_IN_PS              1000000000
`define MS_CYCLES_DEF         (`MS_IN_PS / `CLK_PERIOD_PS)
`define AIS_PERSIST_MS        42
`define YEL_PERSIST_MS        900
// One extra tick because the millisecond divider runs free of the condition
`define AIS_DECL_TICKS        (`AIS_PERSIST_MS + 1)
`define AIS_CLR_TICKS         (`AIS_PERSIST_MS + 1)
`define YEL_DECL_TICKS        (`YEL_PERSIST_MS + 1)
`define YEL_CLR_TICKS         0
`define LOS_BITS              8'd175
`define LOS_DENSITY_PERMILLE  125
`define LOS_ONES_MIN          8'((175 * `LOS_DENSITY_PERMILLE + 999) / 1000)

`endif

// ===== include/defect_mon_pkg.sv
// Types for the T1 receive defect monitor: state enums and the state structs
// of each module. Constants live in defect_mon_defs.svh.
package defect_mon_pkg;

   typedef enum logic [1:0] {
      LOF_IN_FRAME = 2'b01,
      LOF_LOST     = 2'b10
   } lof_state_e;

   typedef struct packed {
      logic [9:0] cnt;
      logic       live;
   } persist_s;

   typedef struct packed {
      logic [16:0] cnt;
      logic        tick;
   } divider_s;

   typedef struct packed {
      lof_state_e lof_state;
      logic [3:0] lof_bits;
      logic [3:0] lof_errs;
      logic [7:0] los_run;
      logic [7:0] los_bits;
      logic [7:0] los_ones;
      logic       los_live;
      logic [2:0] prev_live;
      logic [2:0] chg;
      logic [2:0] mask;
      logic [3:0] tolerance;
      logic [3:0] window;
      logic [7:0] rdata;
      logic       irq;
   } monitor_s;

endpackage : defect_mon_pkg

// ===== include/persist_if.sv
// Carrier between the monitor and one persistence filter.
// Assumes tick is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
interface persist_if;
   logic tick;
   logic cond;
   logic live;

   modport src  (output tick, output cond, input live);
   modport filt (input tick, input cond, output live);
endinterface : persist_if

// ===== rtl/ms_tick_gen.sv
// Free-running divider giving a one-cycle pulse every millisecond.
// Assumes a single clock; MS_CYCLES fits the 17-bit counter.
`timescale 1ns/1ps
`include "defect_mon_defs.svh"
module ms_tick_gen
   import defect_mon_pkg::*;
#(
   parameter int MS_CYCLES = `MS_CYCLES_DEF
) (
   input  wire logic ref_clk,   // System clock
   input  wire logic rst,       // Synchronous reset
   output      logic tick       // One pulse per millisecond
);
   divider_s st;
   divider_s next_st;

   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (st.cnt == 17'(MS_CYCLES - 1)) begin
         next_st.cnt  = 17'h0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = 17'(st.cnt + 17'h1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule : ms_tick_gen

// ===== rtl/defect_persist.sv
// Persistence filter: the live state follows the condition only after the
// condition has held unbroken for a number of ticks. CLR_TICKS of 0 clears at once.
// Assumes tick is a one-cycle pulse and cond is synchronous to ref_clk.
`timescale 1ns/1ps
module defect_persist
   import defect_mon_pkg::*;
#(
   parameter int DECL_TICKS = 1,
   parameter int CLR_TICKS  = 1
) (
   input  wire logic ref_clk,   // System clock
   input  wire logic rst,       // Synchronous reset
   persist_if.filt   p          // Tick, condition and live state
);
   persist_s st;
   persist_s next_st;
   logic [9:0] cnt_inc;

   always_comb begin
      next_st = st;
      cnt_inc = 10'(st.cnt + 10'h1);
      if (p.cond == st.live) begin
         next_st.cnt = 10'h0;
      end else if (!p.cond && CLR_TICKS == 0) begin
         next_st.live = 1'b0;
         next_st.cnt  = 10'h0;
      end else if (p.tick) begin
         if (cnt_inc >= 10'(p.cond ? DECL_TICKS : CLR_TICKS)) begin
            next_st.live = p.cond;
            next_st.cnt  = 10'h0;
         end else begin
            next_st.cnt = cnt_inc;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign p.live = st.live;
endmodule : defect_persist

// ===== rtl/t1_receive_defect_state_monitor.sv
// T1 receive defect monitor: keeps the live loss-of-frame, alarm indication,
// yellow alarm and loss-of-signal states, latches changes of all but loss of signal and raises
// an interrupt, all behind a small register port.
// Assumes all line inputs are synchronous to ref_clk and that the framer
// gives one strobe per received bit and one per framing bit position.
//
// Operation
// [RULE1] Loss of frame declared when framing errors reach tolerance within the window.
// [RULE2] Alarm indication declared after all-ones persists for 42 ms.
// [RULE3] Alarm indication cleared after all-ones absent for 42 ms.
// [RULE4] Yellow alarm declared after remote alarm persists for 900 ms.
// [RULE5] Yellow alarm cleared at once when the remote alarm goes away.
// [RULE6] Loss of signal declared after condition holds 175 consecutive bits.
// [RULE7] Loss of signal cleared when absent or 12.5% ones over 175 bits.
// [RULE8] Live loss of frame at bit 7, alarm indication at bit 6, read-only.
// [RULE9] Live yellow alarm at bit 5, loss of signal at bit 4, read-only.
// [RULE10] Writes to live bits ignored; all four read zero after reset.
// [RULE11] Change flags latch on declare or clear of three states; read clears.
`timescale 1ns/1ps
`include "defect_mon_defs.svh"
module t1_receive_defect_state_monitor
   import defect_mon_pkg::*;
#(
   parameter int MS_CYCLES = `MS_CYCLES_DEF
) (
   input  wire logic       ref_clk,                   // 125 MHz system clock
   input  wire logic       rst,                       // Synchronous reset, active high
   input  wire logic [3:0] reg_addr,                  // Register index
   input  wire logic [7:0] reg_wdata,                 // Write data
   input  wire logic       reg_wr,                    // Write strobe
   input  wire logic       reg_rd,                    // Read strobe
   output      logic [7:0] reg_rdata,                 // Read data, cycle after the strobe
   output      logic       irq,                       // Level interrupt
   input  wire logic       rx_bit_en,                 // One pulse per received bit
   input  wire logic       rx_bit_data,               // Received bit value
   input  wire logic       rx_los_cond,               // Raw loss-of-signal condition
   input  wire logic       rx_fbit_en,                // One pulse per framing bit
   input  wire logic       rx_fbit_err,               // Framing bit pattern error
   input  wire logic       rx_ais_cond,               // All-ones alarm condition
   input  wire logic       rx_rai_cond,               // Remote alarm condition
   output      logic       rx_frame_loss_live,        // Loss of frame declared
   output      logic       rx_alarm_indication_live,  // Alarm indication declared
   output      logic       rx_remote_alarm_live,      // Yellow alarm declared
   output      logic       rx_signal_loss_live        // Loss of signal declared
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] inc8(input logic [7:0] v);
      inc8 = (v == 8'hff) ? v : 8'(v + 8'h01);
   endfunction : inc8

   function automatic logic [3:0] inc4(input logic [3:0] v);
      inc4 = (v == 4'hf) ? v : 4'(v + 4'h1);
   endfunction : inc4

   // ****************************************************************
   // State and sub-blocks
   // ****************************************************************
   monitor_s   st;
   monitor_s   next_st;
   logic       ms_tick;
   logic       lof_live;
   logic [2:0] live_now;
   logic [2:0] chg_evt;
   logic [7:0] status;
   logic [3:0] fbits;
   logic [3:0] ferrs;
   logic [7:0] lbits;
   logic [7:0] lones;
   logic [7:0] lrun;

   persist_if ais_if ();
   persist_if yel_if ();

   ms_tick_gen #(
      .MS_CYCLES (MS_CYCLES)
   ) u_ms_tick (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (ms_tick)
   );

   assign ais_if.tick = ms_tick;
   assign ais_if.cond = rx_ais_cond;
   assign yel_if.tick = ms_tick;
   assign yel_if.cond = rx_rai_cond;

   defect_persist #(
      .DECL_TICKS (`AIS_DECL_TICKS),  // RULE2
      .CLR_TICKS  (`AIS_CLR_TICKS)    // RULE3
   ) u_ais (
      .ref_clk (ref_clk),
      .rst     (rst),
      .p       (ais_if.filt)
   );

   defect_persist #(
      .DECL_TICKS (`YEL_DECL_TICKS),  // RULE4
      .CLR_TICKS  (`YEL_CLR_TICKS)    // RULE5
   ) u_yel (
      .ref_clk (ref_clk),
      .rst     (rst),
      .p       (yel_if.filt)
   );

   // ****************************************************************
   // Status word
   // ****************************************************************
   assign lof_live = (st.lof_state == LOF_LOST);
   assign live_now = {lof_live, ais_if.live, yel_if.live};
   assign chg_evt  = live_now ^ st.prev_live;

   always_comb begin
      status                        = 8'h00;
      status[`ST_FRAME_LOSS_LIVE]   = lof_live;         // RULE8
      status[`ST_ALARM_IND_LIVE]    = ais_if.live;      // RULE8
      status[`ST_REMOTE_ALARM_LIVE] = yel_if.live;      // RULE9
      status[`ST_SIGNAL_LOSS_LIVE]  = st.los_live;      // RULE9
      status[`ST_FRAME_LOSS_CHG]    = st.chg[2];
      status[`ST_ALARM_IND_CHG]     = st.chg[1];
      status[`ST_REMOTE_ALARM_CHG]  = st.chg[0];
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_st       = st;
      next_st.rdata = 8'h00;
      fbits         = inc4(st.lof_bits);
      ferrs         = rx_fbit_err ? inc4(st.lof_errs) : st.lof_errs;
      lbits         = inc8(st.los_bits);
      lones         = rx_bit_data ? inc8(st.los_ones) : st.los_ones;
      lrun          = inc8(st.los_run);

      // Loss of frame: errors counted per observation window of framing bits
      if (rx_fbit_en) begin
         next_st.lof_bits = fbits;
         next_st.lof_errs = ferrs;
         unique case (st.lof_state)
            LOF_IN_FRAME: begin
               if (st.tolerance != 4'h0 && ferrs >= st.tolerance) begin
                  next_st.lof_state = LOF_LOST;  // RULE1
                  next_st.lof_bits  = 4'h0;
                  next_st.lof_errs  = 4'h0;
               end else if (fbits >= st.window) begin
                  next_st.lof_bits = 4'h0;
                  next_st.lof_errs = 4'h0;
               end
            end
            LOF_LOST: begin
               // A whole window below tolerance counts as frame regained
               if (fbits >= st.window) begin
                  if (st.tolerance == 4'h0 || ferrs < st.tolerance) begin
                     next_st.lof_state = LOF_IN_FRAME;
                  end
                  next_st.lof_bits = 4'h0;
                  next_st.lof_errs = 4'h0;
               end
            end
            default: begin
               next_st.lof_state = LOF_IN_FRAME;
            end
         endcase
      end

      // Loss of signal: consecutive-bit run to declare, density block to clear
      if (rx_bit_en) begin
         if (!st.los_live) begin
            if (rx_los_cond) begin
               next_st.los_run = lrun;
               if (lrun >= `LOS_BITS) begin
                  next_st.los_live = 1'b1;      // RULE6
                  next_st.los_run  = 8'h00;
                  next_st.los_bits = 8'h00;
                  next_st.los_ones = 8'h00;
               end
            end else begin
               next_st.los_run = 8'h00;
            end
         end else if (!rx_los_cond) begin
            next_st.los_live = 1'b0;            // RULE7
            next_st.los_bits = 8'h00;
            next_st.los_ones = 8'h00;
         end else begin
            next_st.los_bits = lbits;
            next_st.los_ones = lones;
            if (lbits >= `LOS_BITS) begin
               if (lones >= `LOS_ONES_MIN) begin
                  next_st.los_live = 1'b0;      // RULE7
               end
               next_st.los_bits = 8'h00;
               next_st.los_ones = 8'h00;
            end
         end
      end

      // Change flags: a new edge in the read cycle survives the clear
      next_st.prev_live = live_now;
      if (reg_rd && reg_addr == `REG_ALARM_STATUS) begin
         next_st.chg = chg_evt;                 // RULE11
      end else begin
         next_st.chg = st.chg | chg_evt;        // RULE11
      end

      // Status is read-only; writes to it fall away
      if (reg_wr) begin
         unique case (reg_addr)
            `REG_ALARM_MASK: begin
               next_st.mask = reg_wdata[2:0];
            end
            `REG_FRAME_THRESHOLD: begin
               next_st.tolerance = reg_wdata[3:0];
               next_st.window    = reg_wdata[7:4];
            end
            default: begin
               next_st.mask = st.mask;          // RULE10
            end
         endcase
      end

      if (reg_rd) begin
         unique case (reg_addr)
            `REG_ALARM_STATUS: begin
               next_st.rdata = status;
            end
            `REG_ALARM_MASK: begin
               next_st.rdata = {5'h00, st.mask};
            end
            `REG_FRAME_THRESHOLD: begin
               next_st.rdata = {st.window, st.tolerance};
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end

      next_st.irq = |(next_st.chg & next_st.mask);
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st           <= '0;                    // RULE10
         st.lof_state <= LOF_IN_FRAME;
         st.mask      <= `MASK_RST;
         st.tolerance <= `TOLERANCE_RST;
         st.window    <= `WINDOW_RST;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign reg_rdata                = st.rdata;
   assign irq                      = st.irq;
   assign rx_frame_loss_live       = lof_live;
   assign rx_alarm_indication_live = ais_if.live;
   assign rx_remote_alarm_live     = yel_if.live;
   assign rx_signal_loss_live      = st.los_live;

endmodule : t1_receive_defect_state_monitor

// ===== verif/t1_receive_defect_state_monitor_assertions.sv
// Port-level checks of the T1 receive defect monitor.
// Assumes MS_CYCLES equals that of the bound monitor instance.
`timescale 1ns/1ps
`include "defect_mon_defs.svh"
module defect_monitor_checker #(
   parameter int MS_CYCLES = 125000
) (
   input wire logic       ref_clk,                  // Clock
   input wire logic       rst,                      // Reset
   input wire logic [3:0] reg_addr,                 // Index
   input wire logic       reg_rd,                   // Read strobe
   input wire logic [7:0] reg_rdata,                // Read data
   input wire logic       rx_bit_en,                // Bit strobe
   input wire logic       rx_los_cond,              // Raw LOS
   input wire logic       rx_fbit_en,               // Framing strobe
   input wire logic       rx_ais_cond,              // All ones
   input wire logic       rx_rai_cond,              // Remote alarm
   input wire logic       rx_frame_loss_live,       // LOF live
   input wire logic       rx_alarm_indication_live, // AIS live
   input wire logic       rx_remote_alarm_live,     // Yellow live
   input wire logic       rx_signal_loss_live       // LOS live
);
   localparam int AIS_MIN = 42 * MS_CYCLES;
   localparam int YEL_MIN = 900 * MS_CYCLES;

   int los_run;
   int ais_on;
   int ais_off;
   int rai_on;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // ******************************
   // Run lengths, cleared by any break
   // ******************************
   always_ff @(posedge ref_clk) begin
      los_run <= (rst || (rx_bit_en && !rx_los_cond)) ? 0 : los_run + int'(rx_bit_en);
      ais_on  <= (rst || !rx_ais_cond) ? 0 : ais_on + 1;
      ais_off <= (rst || rx_ais_cond) ? 0 : ais_off + 1;
      rai_on  <= (rst || !rx_rai_cond) ? 0 : rai_on + 1;
   end

   property p_los_decl;
      rx_bit_en && rx_los_cond && !rx_signal_loss_live && los_run == 174
         |-> ##[1:2] rx_signal_loss_live;
   endproperty
   a_los_decl: assert property (p_los_decl) else $error("los not declared");
   property p_los_rise;
      $rose(rx_signal_loss_live) |-> los_run >= 175;
   endproperty
   a_los_rise: assert property (p_los_rise) else $error("los declared early");
   property p_los_clr;
      rx_bit_en && !rx_los_cond && rx_signal_loss_live |-> ##[1:2] !rx_signal_loss_live;
   endproperty
   a_los_clr: assert property (p_los_clr) else $error("los not cleared");
   property p_ais_decl;
      $rose(rx_alarm_indication_live) |-> ais_on >= AIS_MIN;
   endproperty
   a_ais_decl: assert property (p_ais_decl) else $error("ais declared early");
   property p_ais_clr;
      $fell(rx_alarm_indication_live) |-> ais_off >= AIS_MIN;
   endproperty
   a_ais_clr: assert property (p_ais_clr) else $error("ais cleared early");
   property p_yel_decl;
      $rose(rx_remote_alarm_live) |-> rai_on >= YEL_MIN;
   endproperty
   a_yel_decl: assert property (p_yel_decl) else $error("yellow declared early");
   property p_yel_clr;
      rx_remote_alarm_live && !rx_rai_cond |=> !rx_remote_alarm_live;
   endproperty
   a_yel_clr: assert property (p_yel_clr) else $error("yellow held");
   property p_lof_rise;
      $rose(rx_frame_loss_live) |-> $past(rx_fbit_en) || $past(rx_fbit_en, 2);
   endproperty
   a_lof_rise: assert property (p_lof_rise) else $error("lof without framing bit");
   property p_status;
      reg_rd && reg_addr == `REG_ALARM_STATUS |=> reg_rdata[7:4] ==
         {$past(rx_frame_loss_live), $past(rx_alarm_indication_live),
          $past(rx_remote_alarm_live), $past(rx_signal_loss_live)};
   endproperty
   a_status: assert property (p_status) else $error("live bits misplaced");
endmodule : defect_monitor_checker

bind t1_receive_defect_state_monitor defect_monitor_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .ref_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .rx_bit_en, .rx_los_cond, .rx_fbit_en,
   .rx_ais_cond, .rx_rai_cond, .rx_frame_loss_live, .rx_alarm_indication_live,
   .rx_remote_alarm_live, .rx_signal_loss_live
);

// ===== verif/t1_line_source.sv
// Behavioural source of received T1 line data for the defect monitor.
// Assumes one bench process calls its tasks; drives follow a rising edge.
`timescale 1ns/1ps
module t1_line_source (
   input  wire logic ref_clk,     // Clock
   output      logic rx_bit_en,   // Bit strobe
   output      logic rx_bit_data, // Bit value
   output      logic rx_los_cond, // Raw LOS
   output      logic rx_fbit_en,  // Framing strobe
   output      logic rx_fbit_err, // Framing error
   output      logic rx_ais_cond, // All ones
   output      logic rx_rai_cond  // Remote alarm
);
   int nbit;

   initial begin
      nbit        = 0;
      rx_bit_en   = 1'b0;
      rx_bit_data = 1'b0;
      rx_los_cond = 1'b0;
      rx_fbit_en  = 1'b0;
      rx_fbit_err = 1'b0;
      rx_ais_cond = 1'b0;
      rx_rai_cond = 1'b0;
   end

   // Qualifiers flip between strobes so a stale value never passes
   task automatic send_bits(input int n, input logic los, input logic ones);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         rx_bit_en   <= 1'b1;
         rx_los_cond <= los;
         rx_bit_data <= ones && (nbit % 4 == 0);
         nbit++;
         @(posedge ref_clk);
         rx_bit_en   <= 1'b0;
         rx_los_cond <= !los;
         rx_bit_data <= !rx_bit_data;
      end
      #1;
   endtask : send_bits

   task automatic send_fbits(input int n, input logic [7:0] errs);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         rx_fbit_en  <= 1'b1;
         rx_fbit_err <= errs[i];
         @(posedge ref_clk);
         rx_fbit_en  <= 1'b0;
         rx_fbit_err <= !errs[i];
      end
      #1;
   endtask : send_fbits

   task automatic set_alarm(input logic ais, input logic rai);
      @(posedge ref_clk);
      rx_ais_cond <= ais;
      rx_rai_cond <= rai;
      #1;
   endtask : set_alarm
endmodule : t1_line_source

// ===== verif/t1_receive_defect_state_monitor_tb.sv
// Self-checking bench for the T1 receive defect monitor.
// Assumes the line source model and the bound checker; ms divider shortened.
`timescale 1ns/1ps
`include "defect_mon_defs.svh"
module t1_receive_defect_state_monitor_tb;
   localparam int MS = 10;

   logic       ref_clk;
   logic       rst;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       irq;
   logic       rx_bit_en;
   logic       rx_bit_data;
   logic       rx_los_cond;
   logic       rx_fbit_en;
   logic       rx_fbit_err;
   logic       rx_ais_cond;
   logic       rx_rai_cond;
   logic       rx_frame_loss_live;
   logic       rx_alarm_indication_live;
   logic       rx_remote_alarm_live;
   logic       rx_signal_loss_live;
   logic [3:0] live;
   logic [7:0] rd;
   int         err_count;
   int         comparisons;

   assign live = {rx_frame_loss_live, rx_alarm_indication_live, rx_remote_alarm_live,
                  rx_signal_loss_live};

   t1_receive_defect_state_monitor #(.MS_CYCLES(MS)) dut (
      .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
      .rx_bit_en, .rx_bit_data, .rx_los_cond, .rx_fbit_en, .rx_fbit_err, .rx_ais_cond,
      .rx_rai_cond, .rx_frame_loss_live, .rx_alarm_indication_live,
      .rx_remote_alarm_live, .rx_signal_loss_live
   );

   t1_line_source src (
      .ref_clk, .rx_bit_en, .rx_bit_data, .rx_los_cond, .rx_fbit_en, .rx_fbit_err,
      .rx_ais_cond, .rx_rai_cond
   );

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ******************************
   // Shared tasks
   // ******************************
   task automatic conclude();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : idle

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   // A bound that runs out counts as a mismatch and ends the run
   task automatic wait_live(input int b, input logic v, input int lim);
      int i;
      i = 0;
      #1;
      while (live[b] !== v && i < lim) begin
         @(posedge ref_clk);
         #1;
         i++;
      end
      check("live state", 8'(v), 8'(live[b]));
      if (live[b] !== v) conclude();
   endtask : wait_live

   task automatic read_status(input logic [7:0] exp);
      reg_read(`REG_ALARM_STATUS, rd);
      check("status", exp, rd);
   endtask : read_status

   // ******************************
   // Scenarios
   // ******************************
   task automatic s_reset();
      read_status(8'h00);
      reg_read(`REG_ALARM_MASK, rd);
      check("mask", {5'h0, `MASK_RST}, rd);
      reg_read(`REG_FRAME_THRESHOLD, rd);
      check("threshold", {`WINDOW_RST, `TOLERANCE_RST}, rd);
      reg_write(`REG_ALARM_STATUS, 8'hff);
      read_status(8'h00);
      reg_read(4'hf, rd);
      check("unmapped", 8'h00, rd);
   endtask : s_reset

   task automatic s_los();
      int i;
      src.send_bits(174, 1'b1, 1'b0);
      idle(3);
      check("los early", 8'h00, 8'(live[0]));
      src.send_bits(1, 1'b1, 1'b0);
      wait_live(0, 1'b1, 3);
      read_status(8'h10);
      src.send_bits(1, 1'b0, 1'b0);
      wait_live(0, 1'b0, 3);
      src.send_bits(175, 1'b1, 1'b0);
      wait_live(0, 1'b1, 3);
      for (i = 0; i < 400 && live[0] === 1'b1; i++) src.send_bits(1, 1'b1, 1'b1);
      check("los density", 8'h00, 8'(live[0]));
      if (live[0] !== 1'b0) conclude();
      src.send_bits(1, 1'b0, 1'b0);
      check("irq", 8'h00, 8'(irq));
   endtask : s_los

   task automatic s_lof();
      src.send_fbits(8, 8'hff);
      wait_live(3, 1'b1, 3);
      check("irq masked", 8'h00, 8'(irq));
      read_status(8'h84);
      src.send_fbits(6, 8'h00);
      wait_live(3, 1'b0, 3);
      read_status(8'h04);
      src.send_fbits(4, 8'h08);
      idle(3);
      check("lof below tolerance", 8'h00, 8'(live[3]));
      reg_write(`REG_FRAME_THRESHOLD, 8'h41);
      src.send_fbits(4, 8'h08);
      wait_live(3, 1'b1, 3);
      reg_write(`REG_FRAME_THRESHOLD, 8'h42);
      src.send_fbits(4, 8'h00);
      wait_live(3, 1'b0, 3);
      read_status(8'h04);
   endtask : s_lof

   task automatic s_ais();
      reg_write(`REG_ALARM_MASK, 8'h02);
      src.set_alarm(1'b1, 1'b0);
      idle(42 * MS - 2);
      check("ais early", 8'h00, 8'(live[2]));
      wait_live(2, 1'b1, 2 * MS + 4);
      idle(3);
      check("irq", 8'h01, 8'(irq));
      read_status(8'h42);
      idle(2);
      check("irq after read", 8'h00, 8'(irq));
      src.set_alarm(1'b0, 1'b0);
      idle(42 * MS - 2);
      check("ais held", 8'h01, 8'(live[2]));
      wait_live(2, 1'b0, 2 * MS + 4);
      idle(3);
      check("irq", 8'h01, 8'(irq));
      read_status(8'h02);
      reg_write(`REG_ALARM_MASK, 8'h00);
   endtask : s_ais

   task automatic s_yel();
      src.set_alarm(1'b0, 1'b1);
      idle(900 * MS - 2);
      check("yellow early", 8'h00, 8'(live[1]));
      wait_live(1, 1'b1, 2 * MS + 4);
      read_status(8'h21);
      src.set_alarm(1'b0, 1'b0);
      wait_live(1, 1'b0, 2);
      idle(3);
      check("irq masked", 8'h00, 8'(irq));
      read_status(8'h01);
   endtask : s_yel

   initial begin
      err_count   = 0;
      comparisons = 0;
      rst         = 1'b1;
      reg_addr    = 4'h0;
      reg_wdata   = 8'h00;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      s_reset();
      s_los();
      s_lof();
      s_ais();
      s_yel();
      conclude();
   end
endmodule : t1_receive_defect_state_monitor_tb
